/* File: async_rx_data_recovery.sv */
`timescale 1ns/1ps
module async_rx_data_recovery (
    // clock and reset
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_n_in,
    // serial line
    input  wire logic                      rx_serial_in,
    // configuration
    input  wire logic                      rx_enable_in,
    input  wire logic [rx_pkg::DIV_W-1:0]  baud_div_in,
    input  wire logic                      nine_bit_in,
    input  wire logic                      parity_en_in,
    input  wire logic                      parity_odd_in,
    input  wire logic                      wake_addr_mark_in,
    input  wire logic                      idle_count_origin_in,
    // interrupt enables
    input  wire logic                      rx_full_irq_enable_in,
    input  wire logic                      idle_irq_enable_in,
    input  wire logic                      overrun_irq_enable_in,
    input  wire logic                      noise_irq_enable_in,
    input  wire logic                      framing_irq_enable_in,
    input  wire logic                      parity_irq_enable_in,
    // software access
    input  wire logic                      standby_write_in,
    input  wire logic                      standby_wdata_in,
    input  wire logic                      rx_read_in,
    input  wire logic [rx_pkg::CLR_W-1:0]  status_clear_in,
    // data and status
    output logic [rx_pkg::DATA_W-1:0]      rx_data_buffer_out,
    output logic                           rx_full_flag_out,
    output logic                           standby_request_out,
    output logic                           idle_flag_out,
    output logic                           overrun_flag_out,
    output logic                           noise_flag_out,
    output logic                           framing_error_flag_out,
    output logic                           parity_error_flag_out,
    // interrupt requests
    output logic                           rx_irq_out,
    output logic                           err_irq_out
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : vote3

    function automatic logic split3(input logic [2:0] s);
        split3 = (s != 3'b000) && (s != 3'b111);
    endfunction : split3

    // ****************************************
    // declarations
    // ****************************************
    rx_pkg::rx_state_t         state_q;
    logic [rx_pkg::RT_W-1:0]   rt_q;
    logic [2:0]                hist_q;
    logic [1:0]                start_s_q;
    logic [1:0]                vote_q;
    logic [3:0]                bit_idx_q;
    logic [rx_pkg::DATA_W-1:0] shift_q;
    logic                      char_noise_q;
    logic                      last_bit_q;
    logic                      prev_smp_q;
    logic [3:0]                ones_q;
    logic                      standby_q;
    logic                      idle_q;
    logic                      overrun_q;
    logic                      noise_q;
    logic                      framing_q;
    logic                      parity_q;
    logic                      tick;
    logic                      rx;
    logic [rx_pkg::RT_W-1:0]   rt_inc;
    logic [2:0]                votes;
    logic                      bit_val;
    logic                      edge_fall;
    logic                      resync;
    logic [3:0]                nbits;
    logic [3:0]                idle_thr;
    logic                      stop_eval;
    logic [rx_pkg::DATA_W-1:0] char_data;
    logic                      char_fe;
    logic                      char_nf;
    logic                      char_pe;
    logic                      accept;
    logic                      buf_ready;
    logic                      push;
    logic                      drop;
    logic                      one_bit;
    logic                      zero_bit;
    logic                      idle_event;
    logic                      idle_level;
    logic                      wake_idle;
    logic                      wake_addr;

    // ****************************************
    // sample tick and buffer
    // ****************************************
    rx_tick_gen u_tick (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .enable_in   (rx_enable_in),
        .baud_div_in (baud_div_in),
        .tick_out    (tick)
    );

    rx_char_buf #(.WIDTH(rx_pkg::DATA_W)) u_buf (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push),
        .in_ready_out  (buf_ready),
        .in_data_in    (char_data),
        .out_valid_out (rx_full_flag_out),
        .out_ready_in  (rx_read_in),
        .out_data_out  (rx_data_buffer_out)
    );

    // ****************************************
    // per-tick decode
    // ****************************************
    assign rx        = rx_serial_in;
    assign rt_inc    = (rt_q == rx_pkg::RT_LAST) ? rx_pkg::RT_FIRST
                                                 : rt_q + 1'b1;
    assign votes     = {rx, vote_q};
    assign bit_val   = vote3(votes);
    assign edge_fall = prev_smp_q & ~rx;
    // only edges outside the vote window move the count
    assign resync    = last_bit_q & edge_fall
                     & ((rt_q < rx_pkg::RT_VOTE_A)
                     | (rt_q > rx_pkg::RT_VOTE_C));
    assign nbits     = nine_bit_in ? rx_pkg::BITS_LONG : rx_pkg::BITS_SHORT;
    assign idle_thr  = nine_bit_in ? rx_pkg::IDLE_LONG : rx_pkg::IDLE_SHORT;
    assign stop_eval = tick & (state_q == rx_pkg::ST_STOP)
                     & (rt_q == rx_pkg::RT_VOTE_C);

    // ****************************************
    // character completion
    // ****************************************
    // eight-bit mode repeats bit seven in the top position
    assign char_data = nine_bit_in ? shift_q
                                   : {shift_q[8], shift_q[8:1]};
    assign char_fe   = ~bit_val;
    assign char_nf   = char_noise_q | split3(votes);
    assign char_pe   = parity_en_in & ((^char_data[7:0])
                     ^ (nine_bit_in & char_data[8]) ^ parity_odd_in);
    // in standby only an address mark gets through
    assign wake_addr = standby_q & wake_addr_mark_in
                     & char_data[rx_pkg::DATA_W-1];
    assign accept    = ~standby_q | wake_addr;
    assign push      = stop_eval & accept & buf_ready;
    assign drop      = stop_eval & accept & ~buf_ready;

    // ****************************************
    // idle line tracking
    // ****************************************
    always_comb begin
        one_bit  = 1'b0;
        zero_bit = 1'b0;
        if (tick) begin
            unique case (state_q)
                rx_pkg::ST_SEARCH: begin
                    one_bit = (rt_q == rx_pkg::RT_LAST) & rx;
                end
                rx_pkg::ST_START: begin
                    zero_bit = (rt_q == rx_pkg::RT_LAST); // start breaks run
                end
                rx_pkg::ST_DATA: begin
                    if (rt_q == rx_pkg::RT_VOTE_C) begin
                        one_bit  = bit_val & ~idle_count_origin_in;
                        zero_bit = ~bit_val;
                    end
                end
                rx_pkg::ST_STOP: begin
                    if (rt_q == rx_pkg::RT_VOTE_C) begin
                        one_bit  = bit_val & ~idle_count_origin_in;
                        zero_bit = ~bit_val;
                    end
                end
            endcase
        end
    end

    assign idle_event = one_bit & (ones_q == idle_thr - 1'b1);
    assign idle_level = (ones_q >= idle_thr);
    // level test also wakes a standby set on an idle line
    assign wake_idle  = standby_q & ~wake_addr_mark_in
                      & (idle_level | idle_event);

    // consecutive ones, saturating at the threshold
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ones_q <= 4'h0;
        end else if (!rx_enable_in || zero_bit) begin
            ones_q <= 4'h0;
        end else if (one_bit && !idle_level) begin
            ones_q <= ones_q + 1'b1;
        end
    end

    // ****************************************
    // recovery state machine
    // ****************************************
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q      <= rx_pkg::ST_SEARCH;
            rt_q         <= rx_pkg::RT_FIRST;
            hist_q       <= 3'b000;
            start_s_q    <= 2'b11;
            vote_q       <= 2'b11;
            bit_idx_q    <= 4'h0;
            shift_q      <= '0;
            char_noise_q <= 1'b0;
            last_bit_q   <= 1'b0;
            prev_smp_q   <= 1'b1;
        end else if (!rx_enable_in) begin
            state_q      <= rx_pkg::ST_SEARCH;
            rt_q         <= rx_pkg::RT_FIRST;
            hist_q       <= 3'b000;
        end else if (tick) begin
            prev_smp_q <= rx;
            rt_q       <= rt_inc;
            unique case (state_q)
                rx_pkg::ST_SEARCH: begin
                    hist_q <= {hist_q[1:0], rx};
                    if (hist_q == 3'b111 && !rx) begin
                        state_q      <= rx_pkg::ST_START;
                        rt_q         <= rx_pkg::RT_FIRST + 1'b1;
                        char_noise_q <= 1'b0;
                        bit_idx_q    <= 4'h0;
                        last_bit_q   <= 1'b0;
                    end
                end
                rx_pkg::ST_START: begin
                    if (rt_q == rx_pkg::RT_START_A) begin
                        start_s_q[0] <= rx;
                    end
                    if (rt_q == rx_pkg::RT_START_B) begin
                        start_s_q[1] <= rx;
                    end
                    if (rt_q == rx_pkg::RT_START_C) begin
                        if (!vote3({rx, start_s_q})) begin
                            char_noise_q <= |{rx, start_s_q};
                        end else begin
                            state_q <= rx_pkg::ST_SEARCH;
                            rt_q    <= rx_pkg::RT_FIRST;
                            hist_q  <= 3'b000;
                        end
                    end
                    // still a start bit, only marked noisy
                    if (rt_q >= rx_pkg::RT_VOTE_A &&
                        rt_q <= rx_pkg::RT_VOTE_C && rx) begin
                        char_noise_q <= 1'b1;
                    end
                    if (rt_q == rx_pkg::RT_LAST) begin
                        state_q <= rx_pkg::ST_DATA;
                    end
                end
                rx_pkg::ST_DATA: begin
                    if (rt_q == rx_pkg::RT_VOTE_A) begin
                        vote_q[0] <= rx;
                    end
                    if (rt_q == rx_pkg::RT_VOTE_B) begin
                        vote_q[1] <= rx;
                    end
                    if (rt_q == rx_pkg::RT_VOTE_C) begin
                        shift_q    <= {bit_val, shift_q[8:1]};
                        last_bit_q <= bit_val;
                        if (split3(votes)) begin
                            char_noise_q <= 1'b1;
                        end
                    end
                    if (resync) begin
                        rt_q <= rx_pkg::RT_RESYNC;
                    end
                    // an early edge opens the next bit
                    if (rt_q == rx_pkg::RT_LAST ||
                        (resync && rt_q > rx_pkg::RT_VOTE_C)) begin
                        if (bit_idx_q == nbits - 1'b1) begin
                            state_q <= rx_pkg::ST_STOP;
                        end else begin
                            bit_idx_q <= bit_idx_q + 1'b1;
                        end
                    end
                end
                rx_pkg::ST_STOP: begin
                    if (rt_q == rx_pkg::RT_VOTE_A) begin
                        vote_q[0] <= rx;
                    end
                    if (rt_q == rx_pkg::RT_VOTE_B) begin
                        vote_q[1] <= rx;
                    end
                    if (resync && rt_q < rx_pkg::RT_VOTE_A) begin
                        rt_q <= rx_pkg::RT_RESYNC;
                    end
                    // finish at the last vote so the next start is seen
                    if (rt_q == rx_pkg::RT_VOTE_C) begin
                        state_q <= rx_pkg::ST_SEARCH;
                        rt_q    <= rx_pkg::RT_FIRST;
                        hist_q  <= {3{bit_val}};
                    end
                end
                default: begin
                    state_q <= rx_pkg::ST_SEARCH;
                    rt_q    <= rx_pkg::RT_FIRST;
                end
            endcase
        end
    end

    // ****************************************
    // standby request
    // ****************************************
    // software write wins over a wake in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            standby_q <= 1'b0;
        end else if (standby_write_in) begin
            standby_q <= standby_wdata_in;
        end else if ((stop_eval && wake_addr) || wake_idle) begin
            standby_q <= 1'b0;
        end
    end

    // ****************************************
    // sticky status flags, set beats clear
    // ****************************************
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_q    <= 1'b0;
            overrun_q <= 1'b0;
            noise_q   <= 1'b0;
            framing_q <= 1'b0;
            parity_q  <= 1'b0;
        end else begin
            idle_q    <= (idle_q & ~status_clear_in[rx_pkg::CLR_IDLE])
                       | (idle_event & ~standby_q);
            overrun_q <= (overrun_q & ~status_clear_in[rx_pkg::CLR_OVERRUN])
                       | drop;
            noise_q   <= (noise_q & ~status_clear_in[rx_pkg::CLR_NOISE])
                       | (push & char_nf);
            framing_q <= (framing_q & ~status_clear_in[rx_pkg::CLR_FRAMING])
                       | (push & char_fe);
            parity_q  <= (parity_q & ~status_clear_in[rx_pkg::CLR_PARITY])
                       | (push & char_pe);
        end
    end

    // ****************************************
    // outputs and interrupt requests
    // ****************************************
    assign standby_request_out    = standby_q;
    assign idle_flag_out          = idle_q;
    assign overrun_flag_out       = overrun_q;
    assign noise_flag_out         = noise_q;
    assign framing_error_flag_out = framing_q;
    assign parity_error_flag_out  = parity_q;

    assign rx_irq_out  = ~standby_q
                       & ((rx_full_flag_out & rx_full_irq_enable_in)
                       | (idle_q & idle_irq_enable_in));
    assign err_irq_out = (overrun_q & overrun_irq_enable_in)
                       | (noise_q & noise_irq_enable_in)
                       | (framing_q & framing_irq_enable_in)
                       | (parity_q & parity_irq_enable_in);

endmodule : async_rx_data_recovery

/* File: async_rx_data_recovery_assertions.sv */
`timescale 1ns/1ps
module rx_checker (
    // watched ports, packed to save space
    input wire logic ref_clk_in, rst_n_in, rx_read_in, standby_write_in,
    input wire logic wake_addr_mark_in, rx_full_irq_enable_in,
    input wire logic idle_irq_enable_in, overrun_irq_enable_in,
    input wire logic noise_irq_enable_in, framing_irq_enable_in,
    input wire logic parity_irq_enable_in, rx_full_flag_out, rx_irq_out,
    input wire logic standby_request_out, idle_flag_out, overrun_flag_out,
    input wire logic noise_flag_out, framing_error_flag_out, err_irq_out,
    input wire logic parity_error_flag_out,
    input wire logic [rx_pkg::DATA_W-1:0] rx_data_buffer_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // error flags only arrive with a buffered character
    a_fe_with_full: assert property (
        $rose(framing_error_flag_out) |-> rx_full_flag_out)
        else $error("framing flag without full");
    a_noise_with_full: assert property (
        $rose(noise_flag_out) |-> rx_full_flag_out)
        else $error("noise flag without full");
    a_overrun_needs_full: assert property (
        $rose(overrun_flag_out) |-> $past(rx_full_flag_out))
        else $error("overrun on empty buffer");
    a_full_only_read: assert property (
        $fell(rx_full_flag_out) |-> $past(rx_read_in))
        else $error("full dropped without read");
    a_old_char_kept: assert property (
        rx_full_flag_out && !rx_read_in |=> $stable(rx_data_buffer_out))
        else $error("buffered character changed");
    a_idle_not_standby: assert property (
        $rose(idle_flag_out) |-> $past(!standby_request_out))
        else $error("idle flag set in standby");
    a_mark_wake_push: assert property (
        $fell(standby_request_out) && wake_addr_mark_in |->
        rx_full_flag_out || $past(standby_write_in))
        else $error("address wake without character");
    a_err_irq_gate: assert property (err_irq_out ==
        (overrun_flag_out && overrun_irq_enable_in ||
         noise_flag_out && noise_irq_enable_in ||
         framing_error_flag_out && framing_irq_enable_in ||
         parity_error_flag_out && parity_irq_enable_in))
        else $error("error request mismatch");
    a_rx_irq_gate: assert property (rx_irq_out ==
        (!standby_request_out && (rx_full_flag_out && rx_full_irq_enable_in
         || idle_flag_out && idle_irq_enable_in)))
        else $error("receive request mismatch");
    // main scenarios reached
    c_overrun: cover property ($rose(overrun_flag_out));
    c_wake: cover property ($fell(standby_request_out));
    c_idle: cover property ($rose(idle_flag_out));
endmodule : rx_checker
bind async_rx_data_recovery rx_checker chk (.*);

/* File: async_rx_data_recovery_tb_top.sv */
`timescale 1ns/1ps
module async_rx_data_recovery_tb_top;
    // ****
    // stimulus, outputs and counters
    // ****
    logic       ref_clk_in = 1'b0, rst_n_in = 1'b0, line, par_en = 1'b0;
    logic       wake = 1'b0, wr = 1'b0, wd = 1'b0, rd = 1'b0, full, sb, idle;
    logic       ovr, nf, fe, pe, rxi, erri, odd = 1'b0;
    logic [4:0] clr = 5'h00;
    logic [5:0] ien = 6'h3F;
    logic [8:0] data;
    int         failures = 0, compares = 0;
    int         gl[3] = '{8, 23, 152};
    always #20 ref_clk_in = ~ref_clk_in; // 25 MHz
    serial_tx_model tx (.ref_clk_in, .line_out(line));
    async_rx_data_recovery DUT (.ref_clk_in, .rst_n_in, .rx_serial_in(line),
        .rx_enable_in(1'b1), .baud_div_in(13'h0000), .nine_bit_in(1'b0),
        .parity_en_in(par_en), .parity_odd_in(odd), .wake_addr_mark_in(wake),
        .idle_count_origin_in(1'b0), .rx_full_irq_enable_in(ien[0]),
        .idle_irq_enable_in(ien[1]), .overrun_irq_enable_in(ien[2]),
        .noise_irq_enable_in(ien[3]), .framing_irq_enable_in(ien[4]),
        .parity_irq_enable_in(ien[5]), .standby_write_in(wr),
        .standby_wdata_in(wd), .rx_read_in(rd), .status_clear_in(clr),
        .rx_data_buffer_out(data), .rx_full_flag_out(full),
        .standby_request_out(sb), .idle_flag_out(idle),
        .overrun_flag_out(ovr), .noise_flag_out(nf),
        .framing_error_flag_out(fe), .parity_error_flag_out(pe),
        .rx_irq_out(rxi), .err_irq_out(erri));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // one-cycle read, standby write and flag clear
    task automatic poke(input logic r, w, v, input logic [4:0] c);
        @(negedge ref_clk_in) {rd, wr, wd, clr} = {r, w, v, c};
        @(negedge ref_clk_in) {rd, wr, clr} = 7'h00;
        @(negedge ref_clk_in);
    endtask : poke
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // ****
    // tests
    // ****
    initial begin
        repeat (10) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        tx.dip(2);
        tx.send(9'h0A6, 8, 1'b1, -1);
        check({rxi, nf, fe, pe, full, data}, {5'h11, 9'h1A6});
        poke(1'b1, 1'b0, 1'b0, 5'h00);
        check(full, 1'b0);
        $display("test basic done");
        foreach (gl[i]) begin
            tx.send(9'h05A, 8, 1'b1, gl[i]);
            check({erri, nf, fe, data}, {3'h6, 9'h05A});
            poke(1'b1, 1'b0, 1'b0, 5'h04);
        end
        tx.send(9'h000, 8, 1'b0, -1);
        check({erri, fe, full, data}, {3'h7, 9'h000});
        poke(1'b1, 1'b0, 1'b0, 5'h08);
        for (int i = 1; i < 4; i++) tx.send(9'(i * 17), 8, 1'b1, -1);
        check({erri, ovr, data}, {2'h3, 9'h011});
        poke(1'b1, 1'b0, 1'b0, 5'h02);
        check({ovr, data}, {1'b0, 9'h022});
        poke(1'b1, 1'b0, 1'b0, 5'h00);
        par_en = 1'b1;
        tx.send(9'h001, 8, 1'b1, -1);
        check({erri, pe}, 2'h3);
        poke(1'b1, 1'b0, 1'b0, 5'h10);
        odd = 1'b1;
        tx.send(9'h001, 8, 1'b1, -1);
        check({erri, pe, full}, 3'h1);
        poke(1'b1, 1'b0, 1'b0, 5'h00);
        {par_en, wake} = 2'h1;
        poke(1'b0, 1'b1, 1'b1, 5'h00);
        tx.send(9'h012, 8, 1'b1, -1);
        check({full, sb, rxi}, 3'h2);
        tx.send(9'h092, 8, 1'b1, -1);
        check({full, sb, rxi, data}, {3'h5, 9'h192});
        poke(1'b0, 1'b1, 1'b1, 5'h00);
        check({full, sb, rxi}, 3'h6);
        poke(1'b1, 1'b1, 1'b0, 5'h01);
        repeat (192) @(negedge ref_clk_in);
        check({idle, rxi}, 2'h3);
        wake = 1'b0;
        poke(1'b0, 1'b1, 1'b1, 5'h00);
        check(sb, 1'b0);
        $display("test wake done");
        complete_run();
    end
    // watchdog, about three times the expected run
    initial begin
        repeat (7000) @(posedge ref_clk_in);
        failures++;
        complete_run();
    end
endmodule : async_rx_data_recovery_tb_top

/* File: rx_char_buf.sv */
`timescale 1ns/1ps
module rx_char_buf #(
    parameter int unsigned WIDTH = rx_pkg::DATA_W
) (
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    // filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);

    // ****************************************
    // two-entry storage
    // ****************************************
    logic [WIDTH-1:0] mem_q [rx_pkg::BUF_DEPTH];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    // handshakes straight from the fill count
    assign in_ready_out  = (cnt_q != 2'd2);
    assign out_valid_out = (cnt_q != 2'd0);
    assign out_data_out  = mem_q[rd_q];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // entries are written only, never reset; the count guards reads
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // pointers and count
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule : rx_char_buf

/* File: rx_pkg.sv */
package rx_pkg;

    // ****************************************
    // clock and bit timing
    // ****************************************
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned DIV_W         = 13;
    localparam int unsigned RT_W          = 5;
    localparam logic [4:0]  RT_FIRST      = 5'h01;
    localparam logic [4:0]  RT_RESYNC     = 5'h02;
    localparam logic [4:0]  RT_LAST       = 5'h10; // sixteen ticks per bit
    localparam logic [4:0]  RT_START_A    = 5'h03;
    localparam logic [4:0]  RT_START_B    = 5'h05;
    localparam logic [4:0]  RT_START_C    = 5'h07;
    localparam logic [4:0]  RT_VOTE_A     = 5'h08;
    localparam logic [4:0]  RT_VOTE_B     = 5'h09;
    localparam logic [4:0]  RT_VOTE_C     = 5'h0A;

    // ****************************************
    // character format and idle detection
    // ****************************************
    localparam int unsigned DATA_W        = 9;
    localparam logic [3:0]  BITS_SHORT    = 4'h8;
    localparam logic [3:0]  BITS_LONG     = 4'h9;
    localparam logic [3:0]  IDLE_SHORT    = 4'hA; // 10 ones
    localparam logic [3:0]  IDLE_LONG     = 4'hB; // 11 ones
    localparam int unsigned BUF_DEPTH     = 2;

    // ****************************************
    // positions in the status clear vector
    // ****************************************
    localparam int unsigned CLR_IDLE      = 0;
    localparam int unsigned CLR_OVERRUN   = 1;
    localparam int unsigned CLR_NOISE     = 2;
    localparam int unsigned CLR_FRAMING   = 3;
    localparam int unsigned CLR_PARITY    = 4;
    localparam int unsigned CLR_W         = 5;

    // ****************************************
    // receiver states
    // ****************************************
    typedef enum logic [3:0] {
        ST_SEARCH = 4'b0001,
        ST_START  = 4'b0010,
        ST_DATA   = 4'b0100,
        ST_STOP   = 4'b1000
    } rx_state_t;

endpackage : rx_pkg

/* File: rx_tick_gen.sv */
`timescale 1ns/1ps
module rx_tick_gen (
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_n_in,
    // control
    input  wire logic                     enable_in,
    input  wire logic [rx_pkg::DIV_W-1:0] baud_div_in,
    // sixteen times the baud rate
    output logic                          tick_out
);

    // ****************************************
    // divider
    // ****************************************
    logic [rx_pkg::DIV_W-1:0] cnt_q;

    // counts down from the divisor; one pulse per wrap
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else if (!enable_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q    <= baud_div_in;
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q - 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule : rx_tick_gen

/* File: serial_tx_model.sv */
`timescale 1ns/1ps
module serial_tx_model (
    // clock and line
    input  wire logic ref_clk_in,
    output logic      line_out
);
    // ****
    // frames at sixteen clocks a bit
    // ****
    initial line_out = 1'b1; // line rests high
    // too short to pass start checks; idle around it re-arms the search
    task automatic dip(input int n);
        repeat (16) @(negedge ref_clk_in);
        repeat (n) @(negedge ref_clk_in) line_out = 1'b0;
        repeat (16) @(negedge ref_clk_in) line_out = 1'b1;
    endtask : dip
    // g flips one clock, so noise lands on a chosen tick
    task automatic send(input logic [8:0] d, input int n, input logic s,
                        input int g);
        logic v;
        for (int k = 0; k < (n + 2) * 16; k++) begin
            v = (k < 16) ? 1'b0 : (k < n * 16 + 16) ? d[k / 16 - 1] : s;
            @(negedge ref_clk_in) line_out = v ^ (k == g);
        end
        @(negedge ref_clk_in) line_out = 1'b1;
    endtask : send
endmodule : serial_tx_model
